// ===== design/pdrb_pkg.sv
// package: constants for the pwm diagnostic record builder
package pdrb_pkg;
  localparam int          REC_BYTES      = 16;
  localparam int          HDR_BYTES      = 4;
  localparam int          EXT_BYTES      = 12;
  localparam int          NUM_INPUTS     = 16;
  localparam int          NUM_GROUPS     = 4;
  localparam int          GROUP_SIZE     = 4;
  localparam int          INPUTS_PER_LB  = 4;
  localparam logic [3:0]  IDX_CHTYPE     = 4'h4;
  localparam logic [3:0]  IDX_DIAGBITS   = 4'h5;
  localparam logic [3:0]  IDX_NUMCH      = 4'h6;
  localparam logic [3:0]  IDX_GRPERR     = 4'h7;
  localparam logic [3:0]  IDX_LOST0      = 4'h8;
  localparam logic [6:0]  CHTYPE_DI      = 7'h70;
  localparam logic [6:0]  CHTYPE_AI      = 7'h71;
  localparam logic [6:0]  CHTYPE_DO      = 7'h72;
  localparam logic [6:0]  CHTYPE_AO      = 7'h73;
  localparam logic [6:0]  CHTYPE_AIO     = 7'h74;
  localparam int          MORE_TYPES_BIT = 7;
  localparam logic [7:0]  DIAG_BITS_PWM  = 8'h08;
  localparam logic [7:0]  NUM_CH_PWM     = 8'h08;
  // register port map
  localparam logic [4:0]  ADDR_REC0      = 5'h00;
  localparam logic [4:0]  ADDR_STATUS    = 5'h10;
  localparam logic [4:0]  ADDR_MASK      = 5'h11;
  localparam logic [4:0]  ADDR_HDR       = 5'h12;
  localparam logic [4:0]  ADDR_CTRL      = 5'h13;
  localparam logic [1:0]  STATUS_RST     = 2'h0;
  localparam logic [1:0]  MASK_RST       = 2'h0;
  localparam logic [31:0] HDR_RST        = 32'h00000000;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam int          ST_LOST_BIT    = 0;
  localparam int          ST_GRP_BIT     = 1;
endpackage

// ===== design/pdrb_lost_tracker.sv
// one lost-interrupt tracker for a single input
`timescale 1ns/100ps
module pdrb_lost_tracker
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic irqIn,
  input  wire logic irqAck,
  input  wire logic recRead,
  output logic      pendingQ,
  output logic      lostQ,
  output logic      lostEvt
);
  logic pending_reg;
  logic lost_reg;

  assign lostEvt  = irqIn && pending_reg && !irqAck;
  assign pendingQ = pending_reg;
  assign lostQ    = lost_reg;

  // new arrival wins over an ack in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pending_reg <= 1'b0;
    else if (irqIn)
      pending_reg <= 1'b1;
    else if (irqAck)
      pending_reg <= 1'b0;
  end

  // a set in the read cycle survives the read-clear [RQ9]
  always_ff @(posedge core_clk)
  begin
    if (rst)
      lost_reg <= 1'b0;
    else if (lostEvt)
      lost_reg <= 1'b1;
    else if (recRead)
      lost_reg <= 1'b0;
  end
endmodule // pdrb_lost_tracker

// ===== design/pdrb_record_builder.sv
// top: pwm-mode diagnostic record assembly with register port and interrupt
// Behaviour
// RQ1: the record is 4 header bytes followed by 12 module-specific bytes, 16 in all.
// RQ2: bytes 0 to 3 carry an unchanged copy of the basic record header.
// RQ3: byte 4 bits 6 to 0 hold the channel type, 70h for digital input in this mode.
// RQ4: byte 4 bit 7 reads 1 when further channel types exist in the module, else 0.
// RQ5: byte 5 holds 08h, the number of diagnostic bits per channel.
// RQ6: byte 6 holds 08h, the number of channels of the module.
// RQ7: byte 7 bits 0 to 3 flag errors in the four groups of four inputs; bits 7 to 4 read 0.
// RQ8: bytes 8 to 11 flag lost interrupts on even bits, four inputs a byte; odd bits read 0.
// RQ9: a lost flag sets when an input fires again before its ack and holds until read.
`timescale 1ns/100ps
module pdrb_record_builder
  import pdrb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic [15:0] procIrq,
  input  wire logic [15:0] procIrqAck,
  input  wire logic [3:0]  groupErr,
  input  wire logic        moreTypes,
  output logic      [15:0] irqPending,
  output logic             diagIrq
);
  logic [7:0]  recByte [REC_BYTES];
  logic [31:0] hdr_reg;
  logic [3:0]  grpErr_reg;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic [1:0]  mask_reg;
  logic [7:0]  ctrl_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] lostQ;
  logic [15:0] lostEvt;
  logic        recRead;
  logic        grpEvt;

  function automatic logic isAddr(input logic [4:0] a, input logic [4:0] ref_a);
    isAddr = (a == ref_a);
  endfunction

  // reading byte 15 closes the record and clears the lost flags [RQ9]
  assign recRead = regRd && isAddr(regAddr, ADDR_REC0 + 5'(REC_BYTES - 1));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_trk
      pdrb_lost_tracker u_trk
      (
        .core_clk (core_clk),
        .rst      (rst),
        .irqIn    (procIrq[gi]),
        .irqAck   (procIrqAck[gi]),
        .recRead  (recRead),
        .pendingQ (irqPending[gi]),
        .lostQ    (lostQ[gi]),
        .lostEvt  (lostEvt[gi])
      );
    end
  endgenerate

  // header copied verbatim from software [RQ2]
  always_ff @(posedge core_clk)
  begin
    if (rst)
      hdr_reg <= HDR_RST;
    else if (regWr && isAddr(regAddr, ADDR_HDR))
      hdr_reg <= regWdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_reg <= CTRL_RST;
    else if (regWr && isAddr(regAddr, ADDR_CTRL))
      ctrl_reg <= regWdata[7:0];
  end

  // group errors are sampled so the record is stable between edges [RQ7]
  always_ff @(posedge core_clk)
  begin
    if (rst)
      grpErr_reg <= 4'h0;
    else
      grpErr_reg <= groupErr;
  end

  assign grpEvt = |(groupErr & ~grpErr_reg);

  // record assembly: 4 header bytes then 12 module bytes [RQ1]
  always_comb
  begin
    for (int i = 0; i < REC_BYTES; i++)
      recByte[i] = 8'h00;
    for (int i = 0; i < HDR_BYTES; i++)
      recByte[i] = hdr_reg[8*i +: 8]; // [RQ2]
    recByte[IDX_CHTYPE][6:0]            = CHTYPE_DI;  // [RQ3]
    recByte[IDX_CHTYPE][MORE_TYPES_BIT] = moreTypes;  // [RQ4]
    recByte[IDX_DIAGBITS]               = DIAG_BITS_PWM; // [RQ5]
    recByte[IDX_NUMCH]                  = NUM_CH_PWM; // [RQ6]
    recByte[IDX_GRPERR][NUM_GROUPS-1:0] = grpErr_reg; // [RQ7]
    // even bits only, odd bits stay zero [RQ8]
    for (int i = 0; i < NUM_INPUTS; i++)
      recByte[int'(IDX_LOST0) + i / INPUTS_PER_LB][2 * (i % INPUTS_PER_LB)] = lostQ[i];
  end

  // sticky events, write one to clear; a new event beats the clear
  always_comb
  begin
    status_next = status_reg;
    if (regWr && isAddr(regAddr, ADDR_STATUS))
      status_next = status_reg & ~regWdata[1:0];
    if (|lostEvt)
      status_next[ST_LOST_BIT] = 1'b1;
    if (grpEvt)
      status_next[ST_GRP_BIT] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      status_reg <= STATUS_RST;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mask_reg <= MASK_RST;
    else if (regWr && isAddr(regAddr, ADDR_MASK))
      mask_reg <= regWdata[1:0];
  end

  // level output; mask of 1 enables the source
  assign diagIrq = |(status_reg & mask_reg);

  // read mux; unmapped addresses return zero
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (regAddr < ADDR_REC0 + 5'(REC_BYTES))
      rdata_next = {24'h000000, recByte[regAddr[3:0]]};
    else if (isAddr(regAddr, ADDR_STATUS))
      rdata_next = {30'h00000000, status_reg};
    else if (isAddr(regAddr, ADDR_MASK))
      rdata_next = {30'h00000000, mask_reg};
    else if (isAddr(regAddr, ADDR_HDR))
      rdata_next = hdr_reg;
    else if (isAddr(regAddr, ADDR_CTRL))
      rdata_next = {24'h000000, ctrl_reg};
  end

  // data only valid the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_reg <= 32'h00000000;
    else if (regRd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 32'h00000000;
  end

  assign regRdata = rdata_reg;
endmodule // pdrb_record_builder

// ===== tb/pdrb_record_builder_props.sv
// checker: port-level properties of the diagnostic record builder
`timescale 1ns/100ps
module pdrb_props
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [4:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [15:0] procIrq,
  input wire logic [3:0]  groupErr,
  input wire logic        moreTypes,
  input wire logic [15:0] irqPending,
  input wire logic        diagIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // shadow of the header word, updated on the same edge as the design
  logic [31:0] hdrReg;
  always_ff @(posedge core_clk)
    if (rst)
      hdrReg <= 32'h0;
    else if (regWr && regAddr == 5'h12)
      hdrReg <= regWdata;
  a_hdr_copy: assert property (
    regRd && regAddr < 5'h04 |=> regRdata == {24'h0, $past(hdrReg[8*regAddr[1:0] +: 8])})
    else $error("header byte differs");
  a_rec_chtype: assert property (
    regRd && regAddr == 5'h04 |=> regRdata == {24'h0, $past(moreTypes), 7'h70})
    else $error("channel type byte wrong");
  a_rec_diagbits: assert property (regRd && regAddr == 5'h05 |=> regRdata == 32'h08)
    else $error("diag bit count wrong");
  a_rec_numch: assert property (regRd && regAddr == 5'h06 |=> regRdata == 32'h08)
    else $error("channel count wrong");
  a_grp_err: assert property (
    regRd && regAddr == 5'h07 |=> regRdata == {28'h0, $past(groupErr, 2)})
    else $error("group error byte wrong");
  a_lost_odd: assert property (
    regRd && regAddr >= 5'h08 && regAddr <= 5'h0b |=> (regRdata & 32'hffffffaa) == 32'h0)
    else $error("odd or upper lost bit set");
  a_rec_upper: assert property (regRd && regAddr < 5'h10 |=> regRdata[31:8] == 24'h0)
    else $error("record word upper bits set");
  a_pend_set: assert property (
    |procIrq |=> (irqPending & $past(procIrq)) == $past(procIrq))
    else $error("arrival not pending");
  c_lost_read: cover property (regRd && regAddr == 5'h08 ##1 regRdata != 32'h0);
  c_irq_out: cover property (diagIrq);
  c_grp: cover property (groupErr != 4'h0);
endmodule // pdrb_props
bind pdrb_record_builder pdrb_props u_props (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .procIrq(procIrq),
  .groupErr(groupErr), .moreTypes(moreTypes), .irqPending(irqPending), .diagIrq(diagIrq));

// ===== tb/pdrb_ack_model.sv
// partner: diagnostic handler that acknowledges pending interrupts
`timescale 1ns/100ps
module pdrb_ack_model
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ackEn,
  input  wire logic [15:0] irqPending,
  output logic      [15:0] procIrqAck
);
  // a slow handler is modelled by dropping ackEn
  always_ff @(posedge core_clk)
    procIrqAck <= rst ? 16'h0 : irqPending & ~procIrqAck & {16{ackEn}};
endmodule // pdrb_ack_model

// ===== tb/pdrb_record_builder_test.sv
// testbench: register-level tests of the diagnostic record builder
`timescale 1ns/100ps
module pdrb_record_builder_test;
  logic        core_clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0;
  logic        moreTypes = 1'h0, ackEn = 1'h0, diagIrq;
  logic [4:0]  regAddr = 5'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [15:0] procIrq = 16'h0, procIrqAck, irqPending;
  logic [3:0]  groupErr = 4'h0;
  int          num_errors = 0, n_tests = 0;
  always #2 core_clk = ~core_clk;
  pdrb_record_builder dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .procIrq(procIrq), .procIrqAck(procIrqAck), .groupErr(groupErr),
    .moreTypes(moreTypes), .irqPending(irqPending), .diagIrq(diagIrq));
  pdrb_ack_model u_ack (.core_clk(core_clk), .rst(rst), .ackEn(ackEn),
    .irqPending(irqPending), .procIrqAck(procIrqAck));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1;
    chk(regRdata, exp);
  endtask
  // n above one holds the input high, so the second arrival meets a pending one
  task automatic fire(input logic [15:0] m, input int n);
    @(posedge core_clk);
    procIrq <= m;
    repeat (n) @(posedge core_clk);
    procIrq <= 16'h0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #4000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    rd(5'h04, 32'h70);
    @(posedge core_clk) moreTypes <= 1'h1;
    rd(5'h04, 32'hf0);
    rd(5'h05, 32'h08);
    rd(5'h06, 32'h08);
    rd(5'h1f, 32'h0);
    wr(5'h12, 32'h44332211);
    rd(5'h12, 32'h44332211);
    // record bytes are read-only, a write there must leave them alone
    wr(5'h04, 32'h000000ff);
    rd(5'h04, 32'hf0);
    wr(5'h13, 32'h0000005a);
    rd(5'h13, 32'h5a);
    for (int i = 0; i < 4; i++)
      rd(i[4:0], 32'h11 * (i + 1));
    $display("test fixed bytes done");
    @(posedge core_clk) groupErr <= 4'ha;
    wr(5'h11, 32'h3);
    rd(5'h11, 32'h3);
    rd(5'h07, 32'h0a);
    rd(5'h10, 32'h2);
    chk({31'h0, diagIrq}, 32'h1);
    wr(5'h10, 32'h2);
    chk({31'h0, diagIrq}, 32'h0);
    $display("test group errors done");
    for (int k = 0; k < 4; k++)
      fire(16'h1 << (5 * k), 2);
    for (int k = 0; k < 4; k++)
      rd(5'h08 + k[4:0], 32'h1 << (2 * k));
    // no acks yet, so inputs 0, 5, 10 and 15 are still pending
    chk({16'h0, irqPending}, 32'h8421);
    rd(5'h10, 32'h1);
    chk({31'h0, diagIrq}, 32'h1);
    wr(5'h11, 32'h2);
    chk({31'h0, diagIrq}, 32'h0);
    wr(5'h11, 32'h3);
    chk({31'h0, diagIrq}, 32'h1);
    rd(5'h0f, 32'h0);
    rd(5'h08, 32'h0);
    wr(5'h10, 32'h1);
    chk({31'h0, diagIrq}, 32'h0);
    @(posedge core_clk) ackEn <= 1'h1;
    fire(16'h1, 1);
    repeat (3) @(posedge core_clk);
    fire(16'h1, 1);
    rd(5'h08, 32'h0);
    chk({16'h0, irqPending}, 32'h0);
    $display("test lost interrupts done");
    // a reset in mid-run must drop a lost flag, the header and the pending bits
    @(posedge core_clk) ackEn <= 1'h0;
    fire(16'h2, 2);
    rd(5'h08, 32'h04);
    @(posedge core_clk) rst <= 1'h1;
    @(posedge core_clk) rst <= 1'h0;
    rd(5'h08, 32'h0);
    rd(5'h12, 32'h0);
    chk({16'h0, irqPending}, 32'h0);
    chk({31'h0, diagIrq}, 32'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule // pdrb_record_builder_test
